// ---- gpe_map.vh ----
/*
 * Address map, field positions and reset values of the two-port pin controller.
 * Assumes it is included by its bare name from every design file that needs it.
 */
`ifndef GPE_MAP_VH
`define GPE_MAP_VH

// ==========================================================
// address layout (byte offsets inside one port)
`define GPE_PORT_BIT      9
`define GPE_OFS_CTRL      9'h000
`define GPE_OFS_FSEL0     9'h010
`define GPE_OFS_FSEL1     9'h020
`define GPE_OFS_FSEL2     9'h030
`define GPE_OFS_OUTEN     9'h040
`define GPE_OFS_OUTVAL    9'h050
`define GPE_OFS_PINVAL    9'h060
`define GPE_OFS_PULLUP    9'h070
`define GPE_OFS_GLITCH    9'h0C0
`define GPE_OFS_EVENT     9'h180
`define GPE_OFS_FREEZE    9'h1A0
`define GPE_OFS_RELEASE   9'h1E0
`define GPE_OFS_FAULT     9'h1E4
`define GPE_OFS_ISTAT     9'h1F0
`define GPE_OFS_IMASK     9'h1F4
`define GPE_OFS_PINMAP    9'h1F8
`define GPE_OFS_REV       9'h1FC

// ==========================================================
// views of a multi-address register
`define GPE_VIEW_RW       2'h0
`define GPE_VIEW_SET      2'h1
`define GPE_VIEW_CLR      2'h2

// ==========================================================
// slot numbers of the lockable registers
`define GPE_NREG          9
`define GPE_SLOT_CTRL     4'h0
`define GPE_SLOT_FSEL0    4'h1
`define GPE_SLOT_FSEL1    4'h2
`define GPE_SLOT_FSEL2    4'h3
`define GPE_SLOT_OUTEN    4'h4
`define GPE_SLOT_OUTVAL   4'h5
`define GPE_SLOT_PULLUP   4'h6
`define GPE_SLOT_GLITCH   4'h7
`define GPE_SLOT_EVENT    4'h8
`define GPE_SLOT_NONE     4'hF

// ==========================================================
// release and fault register fields
`define GPE_KEY_HI        31
`define GPE_KEY_LO        24
`define GPE_KEY_VAL       8'hAA
`define GPE_RELOFS_HI     9
`define GPE_RELOFS_LO     0
`define GPE_FAULT_BIT     0

// ==========================================================
// reset values and fixed pin maps
`define GPE_P0_CTRL_RST   32'h004DFF5F
`define GPE_P0_FSEL0_RST  32'h00320020
`define GPE_P0_FSEL1_RST  32'h00020080
`define GPE_P0_FSEL2_RST  32'h00100800
`define GPE_P0_PULL_RST   32'h00000001
`define GPE_P0_GLITCH_RST 32'h007FFFFF
`define GPE_P0_PINMAP     32'h007FFFFF
`define GPE_P1_CTRL_RST   32'h00001FCF
`define GPE_P1_FSEL0_RST  32'h00000030
`define GPE_P1_FSEL1_RST  32'h00000030
`define GPE_P1_GLITCH_RST 32'h00001FFF
`define GPE_P1_PINMAP     32'h00001FFF
// arbitrary revision value, carries no meaning
`define GPE_REV_VAL       32'h00000123

`endif

// ---- gpe_port_ctrl.v ----
/*
 * Two-port pin controller: per-pin config registers with four views each,
 * per-pin freeze mask with keyed release, access fault flag, event outputs.
 * Assumes a single AHB-Lite master, whole-word single transfers, and pins
 * arriving asynchronously to clk.
 */
// How it works
// - a pin's event-enable bit lets its input changes out as event pulses, else none.
// - a pin whose freeze bit is one keeps its bit in each of the nine lockable registers of its port.
// - the freeze mask and its clear/toggle views are written only right after a good release.
// - the set view of the freeze mask is always writable.
// - the release offset carries the port offset, so it opens only that port's mask.
// - a release write with a key other than 0xAA in bits 31..24 opens no window and closes any open one.
// - the release register always reads zero.
// - a write that would change a frozen bit, or a write to an unopened protected register, sets the fault flag.
// - each port has a read-only 32-bit implemented-pin map.
// - the revision register is read-only and returns a fixed value.
// - two ports, each pin choosing one of eight functions.
// - registers reset to zero except the listed per-port values.
// - each pin's pull-up comes from its pull-up bit, or from the peripheral while its control bit is zero.
`timescale 1ns/1ns
`include "gpe_map.vh"
module gpe_port_ctrl (
    input  wire         clk,          // 100 MHz
    input  wire         srst,         // sync reset, high
    input  wire         hsel,         // slave select
    input  wire [31:0]  haddr,        // byte address
    input  wire [1:0]   htrans,       // transfer type
    input  wire         hwrite,       // write
    input  wire [2:0]   hsize,        // size, word only
    input  wire [31:0]  hwdata,       // write data
    input  wire         hready,       // bus ready
    output reg          hreadyout,    // slave ready
    output reg          hresp,        // always okay
    output reg  [31:0]  hrdata,       // read data
    input  wire [63:0]  pin_in,       // pin levels, async
    input  wire [63:0]  periph_out,   // peripheral drive value
    input  wire [63:0]  periph_oe,    // peripheral drive enable
    input  wire [63:0]  periph_pull,  // peripheral pull request
    output reg  [63:0]  pin_out_r,    // pin drive value
    output reg  [63:0]  pin_oe_r,     // pin drive enable
    output reg  [63:0]  pullup_r,     // pull-up enable
    output reg  [63:0]  pin_event_r,  // event pulses
    output reg  [191:0] func_sel_r,   // 3 bits per pin
    output reg          irq_r         // interrupt level
);

// ==========================================================
// helpers
function [3:0] slot_of;
    input [8:0] ofs;
    begin
        case ({ofs[8:4], 4'h0})
            `GPE_OFS_CTRL:   slot_of = `GPE_SLOT_CTRL;
            `GPE_OFS_FSEL0:  slot_of = `GPE_SLOT_FSEL0;
            `GPE_OFS_FSEL1:  slot_of = `GPE_SLOT_FSEL1;
            `GPE_OFS_FSEL2:  slot_of = `GPE_SLOT_FSEL2;
            `GPE_OFS_OUTEN:  slot_of = `GPE_SLOT_OUTEN;
            `GPE_OFS_OUTVAL: slot_of = `GPE_SLOT_OUTVAL;
            `GPE_OFS_PULLUP: slot_of = `GPE_SLOT_PULLUP;
            `GPE_OFS_GLITCH: slot_of = `GPE_SLOT_GLITCH;
            `GPE_OFS_EVENT:  slot_of = `GPE_SLOT_EVENT;
            default:         slot_of = `GPE_SLOT_NONE;
        endcase
    end
endfunction

function [31:0] view_apply;
    input [1:0]  view;
    input [31:0] old;
    input [31:0] wv;
    begin
        case (view)
            `GPE_VIEW_RW:  view_apply = wv;
            `GPE_VIEW_SET: view_apply = old | wv;
            `GPE_VIEW_CLR: view_apply = old & ~wv;
            default:       view_apply = old ^ wv;
        endcase
    end
endfunction

function [31:0] rst_val;
    input [4:0] s;
    begin
        case (s)
            5'h00:   rst_val = `GPE_P0_CTRL_RST;
            5'h01:   rst_val = `GPE_P0_FSEL0_RST;
            5'h02:   rst_val = `GPE_P0_FSEL1_RST;
            5'h03:   rst_val = `GPE_P0_FSEL2_RST;
            5'h06:   rst_val = `GPE_P0_PULL_RST;
            5'h07:   rst_val = `GPE_P0_GLITCH_RST;
            5'h09:   rst_val = `GPE_P1_CTRL_RST;
            5'h0A:   rst_val = `GPE_P1_FSEL0_RST;
            5'h0B:   rst_val = `GPE_P1_FSEL1_RST;
            5'h10:   rst_val = `GPE_P1_GLITCH_RST;
            default: rst_val = 32'h00000000;
        endcase
    end
endfunction

function [31:0] pin_map;
    input p;
    begin
        pin_map = p ? `GPE_P1_PINMAP : `GPE_P0_PINMAP;
    end
endfunction

function [4:0] slot_idx;
    input       p;
    input [3:0] s;
    begin
        slot_idx = (p ? 5'd9 : 5'd0) + {1'b0, s};
    end
endfunction

// ==========================================================
// state
reg  [31:0] cfg_r [0:17];        // 9 lockable registers per port
reg  [31:0] frz_r [0:1];         // freeze mask per port
reg  [1:0]  fault_r;             // access fault flag per port
reg  [1:0]  istat_r;             // sticky irq status per port
reg  [1:0]  imask_r;             // irq mask per port
reg         win_r;               // release window open
reg  [9:0]  win_ofs_r;           // offset the window opens
reg         dp_r;                // data phase pending
reg         wr_r;
reg  [7:0]  adr_r;               // haddr[9:2] of data phase
reg  [63:0] s1_r;
reg  [63:0] s2_r;
reg  [63:0] s3_r;

// ==========================================================
// data phase decode
reg         prt;
reg  [8:0]  ofs;
reg  [9:0]  full_ofs;
reg  [1:0]  view;
reg  [3:0]  slot;
reg  [4:0]  sidx;
reg  [31:0] old_v;
reg  [31:0] wv;
reg  [31:0] calc_v;
reg  [31:0] cfg_nxt;
reg         cfg_we;
reg         frz_hit;
reg         frz_ok;
reg  [31:0] frz_nxt;
reg         frz_we;
reg         rel_ok;
reg         fault_ev;
reg         fault_clr;
reg         do_wr;
reg  [31:0] rd_v;
integer     k;

always @* begin
    prt      = adr_r[7];
    ofs      = {adr_r[6:0], 2'b00};
    full_ofs = {adr_r, 2'b00};
    view     = adr_r[1:0];
    slot     = slot_of(ofs);
    sidx     = slot_idx(prt, slot);
    do_wr    = dp_r & wr_r;
    old_v    = (slot != `GPE_SLOT_NONE) ? cfg_r[sidx] : 32'h00000000;
    wv       = hwdata & pin_map(prt);
    calc_v   = view_apply(view, old_v, wv);
    cfg_nxt  = (old_v & frz_r[prt]) | (calc_v & ~frz_r[prt]);
    cfg_we   = do_wr & (slot != `GPE_SLOT_NONE);
    frz_hit  = ({ofs[8:4], 4'h0} == `GPE_OFS_FREEZE);
    frz_ok   = (view == `GPE_VIEW_SET)
             | (win_r & (win_ofs_r == full_ofs));
    frz_nxt  = view_apply(view, frz_r[prt], wv);
    frz_we   = do_wr & frz_hit & frz_ok;
    rel_ok   = do_wr & (ofs == `GPE_OFS_RELEASE)
             & (hwdata[`GPE_KEY_HI:`GPE_KEY_LO] == `GPE_KEY_VAL)
             & (hwdata[`GPE_RELOFS_HI] == prt);
    fault_ev = (cfg_we & (|((calc_v ^ old_v) & frz_r[prt])))
             | (do_wr & frz_hit & ~frz_ok);
    fault_clr = do_wr & (ofs == `GPE_OFS_FAULT) & ~hwdata[`GPE_FAULT_BIT];
    rd_v = 32'h00000000;
    if (slot != `GPE_SLOT_NONE)
        rd_v = old_v;
    else if ({ofs[8:4], 4'h0} == `GPE_OFS_PINVAL)
        rd_v = prt ? s2_r[63:32] : s2_r[31:0];
    else if (frz_hit)
        rd_v = frz_r[prt];
    else begin
        case (ofs)
            `GPE_OFS_FAULT:  rd_v = {31'h0, fault_r[prt]};
            `GPE_OFS_ISTAT:  rd_v = {31'h0, istat_r[prt]};
            `GPE_OFS_IMASK:  rd_v = {31'h0, imask_r[prt]};
            `GPE_OFS_PINMAP: rd_v = pin_map(prt);
            `GPE_OFS_REV:    rd_v = `GPE_REV_VAL;
            default:         rd_v = 32'h00000000;
        endcase
    end
end

// ==========================================================
// bus slave and registers
// one wait state per transfer, so a read never sees a stale word
always @(posedge clk) begin
    if (srst) begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        hrdata    <= 32'h00000000;
        dp_r      <= 1'b0;
        wr_r      <= 1'b0;
        adr_r     <= 8'h00;
        win_r     <= 1'b0;
        win_ofs_r <= 10'h000;
        fault_r   <= 2'b00;
        istat_r   <= 2'b00;
        imask_r   <= 2'b00;
        frz_r[0]  <= 32'h00000000;
        frz_r[1]  <= 32'h00000000;
        for (k = 0; k < 2 * `GPE_NREG; k = k + 1)
            cfg_r[k] <= rst_val(k[4:0]);
    end else begin
        hresp <= 1'b0;
        if (hreadyout & hsel & hready & htrans[1]) begin
            dp_r      <= 1'b1;
            wr_r      <= hwrite;
            adr_r     <= haddr[9:2];
            hreadyout <= 1'b0;
        end else begin
            dp_r      <= 1'b0;
            hreadyout <= 1'b1;
        end
        if (dp_r) begin
            hrdata <= wr_r ? 32'h00000000 : rd_v;
            win_r  <= rel_ok;
            if (rel_ok)
                win_ofs_r <= hwdata[`GPE_RELOFS_HI:`GPE_RELOFS_LO];
        end
        if (cfg_we)
            cfg_r[sidx] <= cfg_nxt;
        if (frz_we)
            frz_r[prt] <= frz_nxt;
        if (do_wr & (ofs == `GPE_OFS_IMASK))
            imask_r[prt] <= hwdata[0];
        for (k = 0; k < 2; k = k + 1) begin
            // set wins over a clear in the same cycle
            fault_r[k] <= (fault_ev & (prt == k[0]))
                        | (fault_r[k] & ~(fault_clr & (prt == k[0])));
            istat_r[k] <= (fault_ev & (prt == k[0]))
                        | (istat_r[k] & ~(dp_r & ~wr_r & (prt == k[0])
                                        & (ofs == `GPE_OFS_ISTAT)));
        end
    end
end

// ==========================================================
// pin side
reg [63:0] ctrl_v;
reg [63:0] ev_v;
always @* begin
    ctrl_v = {cfg_r[slot_idx(1'b1, `GPE_SLOT_CTRL)], cfg_r[slot_idx(1'b0, `GPE_SLOT_CTRL)]};
    ev_v   = {cfg_r[slot_idx(1'b1, `GPE_SLOT_EVENT)], cfg_r[slot_idx(1'b0, `GPE_SLOT_EVENT)]};
end

genvar g;
generate
    for (g = 0; g < 64; g = g + 1) begin : g_pin
        // port number of this pin, one bit so the slot index is not cut silently
        localparam g_port = (g >= 32) ? 1'b1 : 1'b0;
        always @(posedge clk) begin
            if (srst) begin
                pin_out_r[g]          <= 1'b0;
                pin_oe_r[g]           <= 1'b0;
                pullup_r[g]           <= 1'b0;
                func_sel_r[3*g+2:3*g] <= 3'h0;
            end else begin
                pin_out_r[g] <= ctrl_v[g] ? cfg_r[slot_idx(g_port, `GPE_SLOT_OUTVAL)][g % 32]
                                          : periph_out[g];
                pin_oe_r[g]  <= ctrl_v[g] ? cfg_r[slot_idx(g_port, `GPE_SLOT_OUTEN)][g % 32]
                                          : periph_oe[g];
                pullup_r[g]  <= cfg_r[slot_idx(g_port, `GPE_SLOT_PULLUP)][g % 32]
                              | (~ctrl_v[g] & periph_pull[g]);
                func_sel_r[3*g+2:3*g] <= {cfg_r[slot_idx(g_port, `GPE_SLOT_FSEL2)][g % 32],
                                          cfg_r[slot_idx(g_port, `GPE_SLOT_FSEL1)][g % 32],
                                          cfg_r[slot_idx(g_port, `GPE_SLOT_FSEL0)][g % 32]};
            end
        end
    end
endgenerate

// s1_r is read only by s2_r; the chain keeps sampling through reset so a
// pin that already sits high at release gives no false edge
always @(posedge clk) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
end

always @(posedge clk) begin
    if (srst) begin
        pin_event_r <= 64'h0;
        irq_r       <= 1'b0;
    end else begin
        pin_event_r <= (s2_r ^ s3_r) & ev_v;
        irq_r       <= |(istat_r & imask_r);
    end
end

endmodule // gpe_port_ctrl

// ---- gpe_port_ctrl_monitor.sv ----
/* Checker of the pin controller: bus handshake, fixed reads, events, reset outputs.
   Assumes one bus master with hready tied to hreadyout. */
`timescale 1ns/1ns
`include "gpe_map.vh"
module gpe_port_mon (
    input wire        clk,         // clock
    input wire        srst,        // sync reset
    input wire        hsel,        // select
    input wire [31:0] haddr,       // address
    input wire [1:0]  htrans,      // transfer type
    input wire        hwrite,      // write
    input wire        hready,      // bus ready
    input wire        hreadyout,   // slave ready
    input wire        hresp,       // response
    input wire [31:0] hrdata,      // read data
    input wire [63:0] pin_in,      // pin levels
    input wire [63:0] pin_oe_r,    // drive enable
    input wire [63:0] pullup_r,    // pull-up
    input wire [63:0] pin_event_r  // event pulses
);
    // ==========================================================
    // accepted address phases
    wire take = hsel && hready && htrans[1] && hreadyout;
    wire rd   = take && !hwrite;

    // ==========================================================
    // assertions
    rdy_one_low_a: assert property (@(posedge clk) disable iff (srst)
        take |=> !hreadyout ##1 hreadyout) else $error("wait state not one cycle");
    rdy_idle_a: assert property (@(posedge clk) disable iff (srst)
        !take |=> hreadyout) else $error("wait state without transfer");
    resp_okay_a: assert property (@(posedge clk) disable iff (srst)
        hresp == 1'b0) else $error("response not okay");
    data_stands_a: assert property (@(posedge clk) disable iff (srst)
        $past(hreadyout) |-> $stable(hrdata)) else $error("read data moved");
    rel_zero_a: assert property (@(posedge clk) disable iff (srst)
        rd && haddr[8:0] == `GPE_OFS_RELEASE |-> ##2 hrdata == 32'h0)
        else $error("release register not zero");
    rev_fixed_a: assert property (@(posedge clk) disable iff (srst)
        rd && haddr[8:0] == `GPE_OFS_REV |-> ##2 hrdata == `GPE_REV_VAL)
        else $error("revision value wrong");
    pin_map_a: assert property (@(posedge clk) disable iff (srst)
        rd && haddr[8:0] == `GPE_OFS_PINMAP |-> ##2 hrdata ==
        ($past(haddr[9], 2) ? `GPE_P1_PINMAP : `GPE_P0_PINMAP)) else $error("pin map wrong");
    // a pulse needs a synced input change three edges back
    event_cause_a: assert property (@(posedge clk) disable iff (srst)
        (pin_event_r & ~($past(pin_in, 3) ^ $past(pin_in, 4))) == 64'h0)
        else $error("event without pin change");
    reset_out_a: assert property (@(posedge clk)
        $fell(srst) |=> pullup_r[0] && hrdata == 32'h0
        && (pin_oe_r[31:0] & `GPE_P0_CTRL_RST) == 32'h0) else $error("outputs not reset");
endmodule // gpe_port_mon

bind gpe_port_ctrl gpe_port_mon i_gpe_port_mon (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_oe_r(pin_oe_r),
    .pullup_r(pullup_r), .pin_event_r(pin_event_r));

// ---- test_gpe_port_ctrl.sv ----
/* Bench of the pin controller: bus read and write tasks, register sequences.
   Assumes a single slave on the bus, so hready is the slave's hreadyout. */
`timescale 1ns/1ns
`include "gpe_map.vh"
module test_gpe_port_ctrl;
    reg          clk, srst, hsel, hwrite;
    reg  [31:0]  haddr, hwdata, d;
    reg  [1:0]   htrans;
    reg  [63:0]  pin_in, p_out, p_oe, p_pull, acc;
    wire         hrdy, hresp, irq;
    wire [31:0]  hrdata;
    wire [63:0]  pout, poe, pup, pev;
    wire [191:0] fsel;
    integer      errors, n_tests, i;
    reg  [31:0]  ta [0:17];
    reg  [31:0]  te [0:17];

    gpe_port_ctrl i_gpe_port_ctrl (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .periph_out(p_out), .periph_oe(p_oe), .periph_pull(p_pull), .pin_out_r(pout),
        .pin_oe_r(poe), .pullup_r(pup), .pin_event_r(pev), .func_sel_r(fsel), .irq_r(irq));

    // ==========================================================
    // tasks
    task chk(input string n, input [63:0] s, input [63:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // address phase held until hready, then data phase until hready again
    task xfer(input w, input [31:0] a, input [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        d = hrdata;
    endtask
    task wr(input [31:0] a, input [31:0] wd);
        xfer(1'b1, a, wd);
    endtask
    task rc(input [31:0] a, input [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), {32'h0, d}, {32'h0, e});
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errors = errors + 1;
        end_of_test;
    end

    // ==========================================================
    // main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        srst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        pin_in = 64'h0;
        p_out = 64'h0;
        p_oe = {64{1'b1}};
        p_pull = {64{1'b1}};
        ta = '{32'h000, 32'h010, 32'h020, 32'h030, 32'h070, 32'h0C0, 32'h1F8, 32'h1FC,
               32'h200, 32'h210, 32'h220, 32'h230, 32'h2C0, 32'h3F8, 32'h180, 32'h1A0,
               32'h1E4, 32'h1E0};
        te = '{32'h004DFF5F, 32'h00320020, 32'h00020080, 32'h00100800, 32'h1, 32'h007FFFFF,
               32'h007FFFFF, `GPE_REV_VAL, 32'h00001FCF, 32'h30, 32'h30, 32'h0, 32'h1FFF,
               32'h1FFF, 32'h0, 32'h0, 32'h0, 32'h0};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 18; i = i + 1) rc(ta[i], te[i]);
        chk("oe", {51'h0, poe[44:32]}, 64'h30);
        chk("pull", {51'h0, pup[44:32]}, 64'h30);
        $display("test reset done");
        // four views of one vector
        wr(32'h180, 32'h0000F0F0);
        wr(32'h184, 32'h0000000F);
        rc(32'h180, 32'h0000F0FF);
        wr(32'h188, 32'h000000F0);
        rc(32'h180, 32'h0000F00F);
        wr(32'h18C, 32'h0000FFFF);
        rc(32'h180, 32'h00000FF0);
        // pin 4 enabled, pin 0 not
        pin_in <= 64'h11;
        acc = 64'h0;
        repeat (6) begin
            tick;
            acc = acc | pev;
        end
        chk("event", acc, 64'h10);
        wr(32'h010, 32'h000000AA);
        wr(32'h020, 32'h000000CC);
        wr(32'h030, 32'h000000F0);
        p_out <= 64'h20;
        wr(32'h050, 32'h0000000F);
        wr(32'h040, 32'h00000003);
        tick;
        chk("func", {40'h0, fsel[23:0]}, {40'h0, 24'hFAC688});
        chk("pout", {56'h0, pout[7:0]}, 64'h2F);
        chk("poe", {56'h0, poe[7:0]}, 64'hA3);
        wr(32'h100, 32'hFFFFFFFF);
        rc(32'h100, 32'h0);
        $display("test views done");
        // freeze, fault flag and its interrupt
        wr(32'h1A4, 32'h1);
        rc(32'h1A0, 32'h1);
        wr(32'h000, 32'h0);
        rc(32'h000, 32'h1);
        wr(32'h200, 32'h0);
        rc(32'h200, 32'h0);
        chk("irq", {63'h0, irq}, 64'h0);
        wr(32'h1F4, 32'h1);
        tick;
        chk("irq", {63'h0, irq}, 64'h1);
        rc(32'h1F0, 32'h1);
        tick;
        chk("irq", {63'h0, irq}, 64'h0);
        rc(32'h1F0, 32'h0);
        rc(32'h1E4, 32'h1);
        wr(32'h1E4, 32'h1);
        rc(32'h1E4, 32'h1);
        wr(32'h1E4, 32'h0);
        rc(32'h1E4, 32'h0);
        $display("test freeze done");
        // keyed release of the freeze mask
        wr(32'h1A8, 32'h1);
        rc(32'h1A0, 32'h1);
        rc(32'h1E4, 32'h1);
        wr(32'h1E0, 32'h550001A8);
        wr(32'h1A8, 32'h1);
        rc(32'h1A0, 32'h1);
        wr(32'h1E0, 32'hAA0003A8);
        wr(32'h1A8, 32'h1);
        rc(32'h1A0, 32'h1);
        wr(32'h1E0, 32'hAA0001A0);
        wr(32'h1A8, 32'h1);
        rc(32'h1A0, 32'h1);
        wr(32'h1E0, 32'hAA0001A8);
        wr(32'h1A8, 32'h1);
        rc(32'h1A0, 32'h0);
        wr(32'h1E0, 32'hAA0001AC);
        rc(32'h1E0, 32'h0);
        wr(32'h1AC, 32'h2);
        rc(32'h1A0, 32'h0);
        wr(32'h1E0, 32'hAA0001AC);
        wr(32'h1AC, 32'h2);
        wr(32'h1AC, 32'h2);
        rc(32'h1A0, 32'h2);
        wr(32'h000, 32'h0);
        rc(32'h000, 32'h0);
        $display("test release done");
        end_of_test;
    end
endmodule // test_gpe_port_ctrl
